// *** src/limit_test_outputs.v ***
/*
  Limit-test block: compares each completed reading against two pairs of
  thresholds, keeps per-pair fail flags with manual or automatic clearing,
  and drives five output lines to a component handler with selectable
  polarity, optional timed pulses and a latching summary line.
  Assumes configuration writes, readings and sequencer events arrive as
  one-cycle strobes from logic on the same system clock.
*/
`timescale 1ns/10ps
`default_nettype none
`include "limit_test_defs.vh"

// Function
// - Two pairs of signed upper and lower thresholds, range plus or minus 4294967295.
// - Reset thresholds: pair one 1 and -1, pair two 2 and -2.
// - Each limit pair has its own enable; either or both may run.
// - Pair fail flag is 0 inside thresholds, 1 at or beyond either.
// - Fail flag is side-blind; high or low cause reported separately as events.
// - A clear request for a pair returns its fail flag to pass.
// - Auto clear, on by default, clears the flag on entering idle.
// - With auto clear off, the flag holds until an explicit clear.
// - Output polarity selects active high or low, high by default.
// - Output enable defaults off; while off, results never drive the lines.
// - Pulse time 0.001 to 99999.999 s, default 0.002 s.
// - Pulse mode defaults off; failing lines then held at level.
// - Summary line latch enable, off by default.
// - With pair one enabled, indicators show pair one result.
// - Pair one off, pair two on: indicators show pair two, tagged 2.
// - A local limit-disable request clears both pair enables together.
// - Every completed reading is evaluated while limit testing is enabled.
// - Failing line goes high in active-high sense, low in active-low sense.
// - Summary line asserts on any failure; unlatched, releases on an all-pass reading.
// - Latched summary holds until control source is passed or a new scan starts.
// - Lines: 1 lower one, 2 upper one, 3 lower two, 4 upper two, 5 any.
module limit_test_outputs (
  input  wire                    clk_i,
  input  wire                    rst_i,
  // Reading path
  input  wire                    reading_valid_i,
  input  wire signed [`THR_W-1:0] reading_i,
  // Threshold writes, value shared
  input  wire signed [`THR_W-1:0] thr_value_i,
  input  wire                    pair_one_upper_threshold_wr_i,
  input  wire                    pair_one_lower_threshold_wr_i,
  input  wire                    pair_two_upper_threshold_wr_i,
  input  wire                    pair_two_lower_threshold_wr_i,
  // Per-pair controls
  input  wire [1:0]              pair_enable_wr_i,
  input  wire [1:0]              pair_enable_val_i,
  input  wire                    limits_off_local_i,
  input  wire [1:0]              fail_clear_i,
  input  wire [1:0]              auto_clear_wr_i,
  input  wire [1:0]              auto_clear_val_i,
  input  wire                    idle_enter_i,
  // Output configuration, value shared
  input  wire                    cfg_bit_i,
  input  wire                    output_polarity_select_wr_i,
  input  wire                    out_enable_wr_i,
  input  wire                    pulse_mode_wr_i,
  input  wire                    summary_latch_wr_i,
  input  wire                    pulse_time_wr_i,
  input  wire [`PULSE_W-1:0]     pulse_time_ms_i,
  // Sequencer events that release a latched summary
  input  wire                    control_source_pass_i,
  input  wire                    scan_start_i,
  // Status
  output reg  [1:0]              pair_enable_o,
  output reg  [1:0]              auto_clear_o,
  output reg  [1:0]              fail_flag_o,
  output reg                     output_polarity_select_o,
  output reg                     out_enable_o,
  output reg                     pulse_mode_o,
  output reg                     summary_latch_o,
  output reg  [`PULSE_W-1:0]     pulse_time_ms_o,
  output reg signed [`THR_W-1:0] pair_one_upper_threshold_o,
  output reg signed [`THR_W-1:0] pair_one_lower_threshold_o,
  output reg signed [`THR_W-1:0] pair_two_upper_threshold_o,
  output reg signed [`THR_W-1:0] pair_two_lower_threshold_o,
  // Measurement event pulses: which side failed
  output reg  [1:0]              high_event_o,
  output reg  [1:0]              low_event_o,
  // Front-panel indicators
  output reg                     ind_high_o,
  output reg                     ind_in_o,
  output reg                     ind_low_o,
  output reg                     ind_pair_two_o,
  // Digital output lines toward the handler
  output reg  [`LINE_N-1:0]      dout_o,
  output reg                     summary_fail_output_o
);

  // Clamp a written value into the documented threshold range
  function signed [`THR_W-1:0] clamp_thr;
    input signed [`THR_W-1:0] v;
    begin
      if (v > `THR_MAX)
        clamp_thr = `THR_MAX;
      else if (v < `THR_MIN)
        clamp_thr = `THR_MIN;
      else
        clamp_thr = v;
    end
  endfunction

  // Clamp a pulse time into 1 .. 99999999 ms
  function [`PULSE_W-1:0] clamp_ms;
    input [`PULSE_W-1:0] v;
    begin
      if (v < `PULSE_MS_MIN)
        clamp_ms = `PULSE_MS_MIN;
      else if (v > `PULSE_MS_MAX)
        clamp_ms = `PULSE_MS_MAX;
      else
        clamp_ms = v;
    end
  endfunction

  // Threshold storage
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      pair_one_upper_threshold_o <= `P1_UPPER_RST;
      pair_one_lower_threshold_o <= `P1_LOWER_RST;
      pair_two_upper_threshold_o <= `P2_UPPER_RST;
      pair_two_lower_threshold_o <= `P2_LOWER_RST;
    end else begin
      if (pair_one_upper_threshold_wr_i)
        pair_one_upper_threshold_o <= clamp_thr(thr_value_i);
      if (pair_one_lower_threshold_wr_i)
        pair_one_lower_threshold_o <= clamp_thr(thr_value_i);
      if (pair_two_upper_threshold_wr_i)
        pair_two_upper_threshold_o <= clamp_thr(thr_value_i);
      if (pair_two_lower_threshold_wr_i)
        pair_two_lower_threshold_o <= clamp_thr(thr_value_i);
    end
  end

  // Settings; the local disable wins over a remote enable in the same cycle
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      pair_enable_o            <= 2'b00;
      auto_clear_o             <= {2{`AUTO_CLEAR_RST}};
      output_polarity_select_o <= `POLARITY_RST;
      out_enable_o             <= `OUT_ENABLE_RST;
      pulse_mode_o             <= `PULSE_MODE_RST;
      summary_latch_o          <= `LATCH_RST;
      pulse_time_ms_o          <= `PULSE_MS_RST;
    end else begin
      if (limits_off_local_i)
        pair_enable_o <= 2'b00;
      else
        pair_enable_o <= (pair_enable_o & ~pair_enable_wr_i) |
                         (pair_enable_val_i & pair_enable_wr_i);
      auto_clear_o <= (auto_clear_o & ~auto_clear_wr_i) | (auto_clear_val_i & auto_clear_wr_i);
      if (output_polarity_select_wr_i)
        output_polarity_select_o <= cfg_bit_i;
      if (out_enable_wr_i)
        out_enable_o <= cfg_bit_i;
      if (pulse_mode_wr_i)
        pulse_mode_o <= cfg_bit_i;
      if (summary_latch_wr_i)
        summary_latch_o <= cfg_bit_i;
      if (pulse_time_wr_i)
        pulse_time_ms_o <= clamp_ms(pulse_time_ms_i);
    end
  end

  // Compare: reaching a threshold counts as a failure
  wire       eval = reading_valid_i && (pair_enable_o != 2'b00);
  wire [3:0] side_fail;
  assign side_fail[`LINE_P1_LOW]  = pair_enable_o[0] && (reading_i <= pair_one_lower_threshold_o);
  assign side_fail[`LINE_P1_HIGH] = pair_enable_o[0] && (reading_i >= pair_one_upper_threshold_o);
  assign side_fail[`LINE_P2_LOW]  = pair_enable_o[1] && (reading_i <= pair_two_lower_threshold_o);
  assign side_fail[`LINE_P2_HIGH] = pair_enable_o[1] && (reading_i >= pair_two_upper_threshold_o);
  wire       any_fail = |side_fail;

  // Per-pair sticky flags; a failing reading beats a clear in the same cycle
  genvar p;
  generate
    for (p = 0; p < 2; p = p + 1) begin : g_pair
      wire pair_fail = side_fail[2*p] | side_fail[2*p+1];
      wire clr = fail_clear_i[p] | (auto_clear_o[p] & idle_enter_i);
      always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
          fail_flag_o[p]  <= 1'b0;
          high_event_o[p] <= 1'b0;
          low_event_o[p]  <= 1'b0;
        end else begin
          if (eval && pair_fail)
            fail_flag_o[p] <= 1'b1;
          else if (clr)
            fail_flag_o[p] <= 1'b0;
          high_event_o[p] <= eval & side_fail[2*p+1];
          low_event_o[p]  <= eval & side_fail[2*p];
        end
      end
    end
  endgenerate

  // Indicators follow pair one when enabled, else pair two
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ind_high_o     <= 1'b0;
      ind_in_o       <= 1'b0;
      ind_low_o      <= 1'b0;
      ind_pair_two_o <= 1'b0;
    end else if (eval) begin
      if (pair_enable_o[0]) begin
        ind_high_o     <= side_fail[`LINE_P1_HIGH];
        ind_low_o      <= side_fail[`LINE_P1_LOW];
        ind_in_o       <= ~(side_fail[`LINE_P1_HIGH] | side_fail[`LINE_P1_LOW]);
        ind_pair_two_o <= 1'b0;
      end else begin
        ind_high_o     <= side_fail[`LINE_P2_HIGH];
        ind_low_o      <= side_fail[`LINE_P2_LOW];
        ind_in_o       <= ~(side_fail[`LINE_P2_HIGH] | side_fail[`LINE_P2_LOW]);
        ind_pair_two_o <= 1'b1;
      end
    end else if (pair_enable_o == 2'b00) begin
      ind_high_o     <= 1'b0;
      ind_in_o       <= 1'b0;
      ind_low_o      <= 1'b0;
      ind_pair_two_o <= 1'b0;
    end
  end

  // Line timers: four threshold lines plus the summary line
  wire [`LINE_N-1:0] line_fail = {any_fail, side_fail};
  wire [`LINE_N-1:0] line_active;
  genvar l;
  generate
    for (l = 0; l < `LINE_N; l = l + 1) begin : g_line
      pulse_stretcher u_timer (
        .clk_i        (clk_i),
        .rst_i        (rst_i),
        .eval_i       (eval),
        .fail_i       (line_fail[l]),
        .pulse_mode_i (pulse_mode_o),
        .pulse_ms_i   (pulse_time_ms_o),
        .active_o     (line_active[l])
      );
    end
  endgenerate

  // Summary latch: held until control source passed or a new scan starts
  reg summary_held;
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i)
      summary_held <= 1'b0;
    else if (summary_latch_o && eval && any_fail)
      summary_held <= 1'b1;
    else if (!summary_latch_o || control_source_pass_i || scan_start_i)
      summary_held <= 1'b0;
  end

  // Line drive; a disabled port sits at the inactive level for the sense
  wire [`LINE_N-1:0] assert_mask = {line_active[`LINE_SUMMARY] | summary_held,
                                    line_active[`LINE_P2_HIGH:0]};
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      dout_o                <= {`LINE_N{1'b0}};
      summary_fail_output_o <= 1'b0;
    end else begin
      dout_o <= (out_enable_o ? assert_mask : {`LINE_N{1'b0}}) ^
                {`LINE_N{output_polarity_select_o}};
      summary_fail_output_o <= out_enable_o & assert_mask[`LINE_SUMMARY];
    end
  end

endmodule // limit_test_outputs

`default_nettype wire

// *** src/limit_test_defs.vh ***
/*
  Constants for the limit-test and digital output block: threshold width,
  reset values of thresholds and settings, pulse timing and line numbering.
  Assumes a 50 MHz system clock and two's-complement 33-bit thresholds.
*/
`ifndef LIMIT_TEST_DEFS_VH
`define LIMIT_TEST_DEFS_VH

// Thresholds span -4294967295 .. +4294967295, so 33 signed bits
`define THR_W            33
`define THR_MAX          33'sd4294967295
`define THR_MIN          -33'sd4294967295

// Reset values of the four thresholds
`define P1_UPPER_RST     33'sd1
`define P1_LOWER_RST     -33'sd1
`define P2_UPPER_RST     33'sd2
`define P2_LOWER_RST     -33'sd2

// Reset values of the settings
`define AUTO_CLEAR_RST   1'b1
`define POLARITY_RST     1'b0
`define OUT_ENABLE_RST   1'b0
`define PULSE_MODE_RST   1'b0
`define LATCH_RST        1'b0

// Pulse time is held in milliseconds: 1 .. 99999999 ms
`define PULSE_W          27
`define PULSE_MS_MIN     27'd1
`define PULSE_MS_MAX     27'd99999999
`define PULSE_MS_RST     27'd2

// Clock rate and cycles per millisecond; the count is sized to the
// millisecond prescaler so it compares without a width change
`define CLK_HZ           50000000
`define CYC_PER_MS       16'd50000
`define MS_CNT_W         16

// Output line positions, line 1 at bit 0
`define LINE_P1_LOW      0
`define LINE_P1_HIGH     1
`define LINE_P2_LOW      2
`define LINE_P2_HIGH     3
`define LINE_SUMMARY     4
`define LINE_N           5

`endif

// *** src/pulse_stretcher.v ***
/*
  One output line timer: holds a fail level for the programmed number of
  milliseconds after each failing reading, or follows the level when not in
  pulse mode. Assumes a one-cycle evaluation strobe on the system clock.
*/
`timescale 1ns/10ps
`default_nettype none
`include "limit_test_defs.vh"

module pulse_stretcher (
  input  wire                 clk_i,
  input  wire                 rst_i,
  input  wire                 eval_i,
  input  wire                 fail_i,
  input  wire                 pulse_mode_i,
  input  wire [`PULSE_W-1:0]  pulse_ms_i,
  output reg                  active_o
);

  reg [`MS_CNT_W-1:0] cyc_cnt;
  reg [`PULSE_W-1:0]  ms_left;

  // A new failing reading restarts the pulse; a passing one ends it at once
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      active_o <= 1'b0;
      cyc_cnt  <= {`MS_CNT_W{1'b0}};
      ms_left  <= {`PULSE_W{1'b0}};
    end else if (!pulse_mode_i) begin
      cyc_cnt <= {`MS_CNT_W{1'b0}};
      ms_left <= {`PULSE_W{1'b0}};
      if (eval_i) begin
        active_o <= fail_i;
      end
    end else if (eval_i) begin
      active_o <= fail_i;
      cyc_cnt  <= {`MS_CNT_W{1'b0}};
      ms_left  <= (pulse_ms_i < `PULSE_MS_MIN) ? `PULSE_MS_MIN : pulse_ms_i;
    end else if (active_o) begin
      // Duration counted on the system clock, one millisecond at a time
      if (cyc_cnt == `CYC_PER_MS - 16'd1) begin
        cyc_cnt <= {`MS_CNT_W{1'b0}};
        if (ms_left <= 27'd1) begin
          active_o <= 1'b0;
          ms_left  <= {`PULSE_W{1'b0}};
        end else begin
          ms_left <= ms_left - 27'd1;
        end
      end else begin
        cyc_cnt <= cyc_cnt + 16'd1;
      end
    end
  end

endmodule // pulse_stretcher

`default_nettype wire

// *** tb/limit_test_outputs_properties.sv ***
/*
  Checker for the limit-test block: flag, event, clear, latch and readback
  timing seen at its ports. Assumes one clock domain and the bind below.
*/
`timescale 1ns/10ps
`default_nettype none
`include "limit_test_defs.vh"
module limit_test_props (
  input wire logic                    clk_i,
  input wire logic                    rst_i,
  input wire logic                    reading_valid_i,
  input wire logic signed [`THR_W-1:0] reading_i,
  input wire logic signed [`THR_W-1:0] thr_value_i,
  input wire logic                    pair_one_upper_threshold_wr_i,
  input wire logic                    limits_off_local_i,
  input wire logic [1:0]              fail_clear_i,
  input wire logic                    idle_enter_i,
  input wire logic                    control_source_pass_i,
  input wire logic                    scan_start_i,
  input wire logic                    summary_latch_wr_i,
  input wire logic                    out_enable_wr_i,
  input wire logic [1:0]              pair_enable_o,
  input wire logic [1:0]              auto_clear_o,
  input wire logic [1:0]              fail_flag_o,
  input wire logic                    out_enable_o,
  input wire logic                    summary_latch_o,
  input wire logic signed [`THR_W-1:0] pair_one_upper_threshold_o,
  input wire logic signed [`THR_W-1:0] pair_one_lower_threshold_o,
  input wire logic [1:0]              high_event_o,
  input wire logic [1:0]              low_event_o,
  input wire logic                    ind_pair_two_o,
  input wire logic                    summary_fail_output_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Pair one reading; crossed thresholds are excluded since both sides would fire
  wire p1_rd = reading_valid_i && pair_enable_o[0];
  wire hi_ok = pair_one_upper_threshold_o > pair_one_lower_threshold_o;
  wire quiet = !control_source_pass_i && !scan_start_i && !summary_latch_wr_i && !out_enable_wr_i && !reading_valid_i;
  property p_high_fail;
    p1_rd && hi_ok && reading_i >= pair_one_upper_threshold_o |=> fail_flag_o[0] && high_event_o[0] && !low_event_o[0];
  endproperty
  a_high_fail: assert property (p_high_fail) else $error("upper crossing not flagged");
  property p_low_fail;
    p1_rd && hi_ok && reading_i <= pair_one_lower_threshold_o |=> fail_flag_o[0] && low_event_o[0] && !high_event_o[0];
  endproperty
  a_low_fail: assert property (p_low_fail) else $error("lower crossing not flagged");
  property p_clear;
    fail_clear_i[0] && !reading_valid_i |=> !fail_flag_o[0];
  endproperty
  a_clear: assert property (p_clear) else $error("clear request ignored");
  property p_auto;
    idle_enter_i && auto_clear_o[1] && !reading_valid_i |=> !fail_flag_o[1];
  endproperty
  a_auto: assert property (p_auto) else $error("idle entry did not clear flag");
  property p_hold;
    fail_flag_o[0] && !auto_clear_o[0] && !fail_clear_i[0] |=> fail_flag_o[0];
  endproperty
  a_hold: assert property (p_hold) else $error("flag dropped without clear");
  property p_off;
    limits_off_local_i |=> pair_enable_o == 2'b00;
  endproperty
  a_off: assert property (p_off) else $error("local disable left a pair on");
  property p_thr;
    pair_one_upper_threshold_wr_i && thr_value_i <= `THR_MAX && thr_value_i >= `THR_MIN
      |=> pair_one_upper_threshold_o == $past(thr_value_i);
  endproperty
  a_thr: assert property (p_thr) else $error("threshold write lost");
  property p_two;
    reading_valid_i && pair_enable_o == 2'b10 |=> ind_pair_two_o;
  endproperty
  a_two: assert property (p_two) else $error("pair two tag missing");
  // Two quiet cycles so a release taken just before cannot reach the line here
  property p_latch;
    quiet [*2] ##0 summary_latch_o && out_enable_o && summary_fail_output_o |=> summary_fail_output_o;
  endproperty
  a_latch: assert property (p_latch) else $error("latched summary released");
  c_fail: cover property (p1_rd && reading_i >= pair_one_upper_threshold_o);
  c_idle: cover property (idle_enter_i && fail_flag_o[1]);
  c_rel: cover property (summary_latch_o && scan_start_i && summary_fail_output_o);
endmodule // limit_test_props
bind limit_test_outputs limit_test_props u_props (.*);
`default_nettype wire

// *** tb/handler_model.sv ***
/*
  Component handler on the five output lines: decodes which lines sit at
  their active level. Assumes it is told the sense the block drives.
*/
`timescale 1ns/10ps
`default_nettype none
module handler_model (
  input  wire logic       low_sense_i,
  input  wire logic [4:0] line_i,
  output logic      [4:0] asserted_o
);
  // Handler only reacts to levels, so sense decoding is all it needs
  assign asserted_o = line_i ^ {5{low_sense_i}};
endmodule // handler_model
`default_nettype wire

// *** tb/tb_limit_test_outputs.sv ***
/*
  Testbench for the limit-test block: task sequences with expected values.
  Assumes design sources, checker and handler model are compiled first.
*/
`timescale 1ns/10ps
`default_nettype none
`include "limit_test_defs.vh"
module tb_limit_test_outputs;
  logic clk_i, rst_i, reading_valid_i, limits_off_local_i, idle_enter_i, cfg_bit_i, pulse_time_wr_i;
  logic pair_one_upper_threshold_wr_i, pair_one_lower_threshold_wr_i, control_source_pass_i, scan_start_i;
  logic pair_two_upper_threshold_wr_i, pair_two_lower_threshold_wr_i, out_enable_wr_i, pulse_mode_wr_i;
  logic output_polarity_select_wr_i, summary_latch_wr_i, output_polarity_select_o, out_enable_o;
  logic pulse_mode_o, summary_latch_o, ind_high_o, ind_in_o, ind_low_o, ind_pair_two_o, summary_fail_output_o;
  logic signed [`THR_W-1:0] reading_i, thr_value_i, pair_one_upper_threshold_o, pair_one_lower_threshold_o;
  logic signed [`THR_W-1:0] pair_two_upper_threshold_o, pair_two_lower_threshold_o;
  logic [1:0] pair_enable_wr_i, pair_enable_val_i, fail_clear_i, auto_clear_wr_i, auto_clear_val_i;
  logic [1:0] pair_enable_o, auto_clear_o, fail_flag_o, high_event_o, low_event_o;
  logic [`PULSE_W-1:0] pulse_time_ms_i, pulse_time_ms_o;
  logic [`LINE_N-1:0] dout_o, seen;
  logic signed [`THR_W-1:0] rv [5] = '{-1, 1, -2, 2, 0};
  logic [9:0] ex [5] = '{10'h0b1, 10'h232, 10'h0f5, 10'h27a, 10'h100};
  int bad_count, n_checks;
  limit_test_outputs dut (.*);
  handler_model hm (.low_sense_i(output_polarity_select_o), .line_i(dout_o), .asserted_o(seen));
  task automatic chk(input logic [79:0] got, input logic [79:0] exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Inputs move 2 ns after the edge so the design samples settled values
  task automatic cyc(input int n = 1);
    repeat (n) @(posedge clk_i);
    #2;
  endtask
  task automatic rd(input logic signed [`THR_W-1:0] v);
    reading_i = v;
    reading_valid_i = 1;
    cyc;
    reading_valid_i = 0;
    cyc;
  endtask
  // k: 0 polarity, 1 output enable, 2 pulse mode, 3 summary latch
  task automatic setb(input int k, input logic b);
    cfg_bit_i = b;
    {summary_latch_wr_i, pulse_mode_wr_i, out_enable_wr_i, output_polarity_select_wr_i} = 4'h1 << k;
    cyc;
    {summary_latch_wr_i, pulse_mode_wr_i, out_enable_wr_i, output_polarity_select_wr_i} = 4'h0;
    cyc;
  endtask
  task automatic thr(input int k, input logic signed [`THR_W-1:0] v);
    thr_value_i = v;
    {pair_two_lower_threshold_wr_i, pair_two_upper_threshold_wr_i,
     pair_one_lower_threshold_wr_i, pair_one_upper_threshold_wr_i} = 4'h1 << k;
    cyc;
    {pair_two_lower_threshold_wr_i, pair_two_upper_threshold_wr_i,
     pair_one_lower_threshold_wr_i, pair_one_upper_threshold_wr_i} = 4'h0;
    cyc;
  endtask
  task automatic en(input logic [1:0] v);
    pair_enable_val_i = v;
    pair_enable_wr_i = 2'h3;
    cyc;
    pair_enable_wr_i = 2'h0;
    cyc;
  endtask
  task automatic clr;
    fail_clear_i = 2'h3;
    cyc;
    fail_clear_i = 2'h0;
    cyc;
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  initial begin
    clk_i = 0;
    forever #10 clk_i = ~clk_i;
  end
  // Whole run is near 50.2k cycles; 70k cycles leaves margin yet keeps a hang short
  initial begin
    #1400000;
    bad_count++;
    final_report;
  end
  initial begin
    {reading_valid_i, limits_off_local_i, idle_enter_i, cfg_bit_i, pulse_time_wr_i, scan_start_i} = 6'h0;
    {pair_one_upper_threshold_wr_i, pair_one_lower_threshold_wr_i, control_source_pass_i} = 3'h0;
    {pair_two_upper_threshold_wr_i, pair_two_lower_threshold_wr_i, out_enable_wr_i, pulse_mode_wr_i} = 4'h0;
    {output_polarity_select_wr_i, summary_latch_wr_i, reading_i, thr_value_i} = 68'h0;
    {pair_enable_wr_i, pair_enable_val_i, fail_clear_i, auto_clear_wr_i, auto_clear_val_i} = 10'h0;
    pulse_time_ms_i = 27'h0;
    rst_i = 1;
    cyc(4);
    rst_i = 0;
    chk({pair_one_upper_threshold_o, pair_two_upper_threshold_o}, {33'sh1, 33'sh2});
    chk({pair_one_lower_threshold_o, pair_two_lower_threshold_o}, {-33'sh1, -33'sh2});
    chk({pair_enable_o, auto_clear_o, output_polarity_select_o, out_enable_o}, 6'h0c);
    chk({pulse_mode_o, summary_latch_o, fail_flag_o, pulse_time_ms_o}, 31'h2);
    thr(0, 33'sh0ffffffff);
    thr(1, 33'sh100000000);
    chk({pair_one_upper_threshold_o, pair_one_lower_threshold_o}, {33'sh0ffffffff, -33'sh0ffffffff});
    // Pair two strobes, then back to the reset values the later tests rely on
    thr(2, 33'sh7);
    thr(3, -33'sh7);
    chk({pair_two_upper_threshold_o, pair_two_lower_threshold_o}, {33'sh7, -33'sh7});
    thr(2, 33'sh2);
    thr(3, -33'sh2);
    thr(0, 33'sh1);
    thr(1, -33'sh1);
    en(2'h3);
    setb(1, 1);
    rd(-1);
    chk(fail_flag_o, 2'h1);
    idle_enter_i = 1;
    cyc;
    idle_enter_i = 0;
    chk(fail_flag_o, 2'h0);
    auto_clear_wr_i = 2'h3;
    cyc;
    auto_clear_wr_i = 2'h0;
    rd(2);
    idle_enter_i = 1;
    cyc;
    idle_enter_i = 0;
    chk({auto_clear_o, fail_flag_o}, 4'h3);
    fail_clear_i = 2'h1;
    cyc;
    chk(fail_flag_o, 2'h2);
    fail_clear_i = 2'h2;
    cyc;
    fail_clear_i = 2'h0;
    // Line map, sticky flags and indicators for each side of both pairs
    for (int i = 0; i < 5; i++) begin
      rd(rv[i]);
      chk({ind_high_o, ind_in_o, ind_low_o, fail_flag_o, seen}, ex[i]);
      clr;
    end
    setb(0, 1);
    rd(-1);
    chk(dout_o, 5'h0e);
    setb(1, 0);
    rd(2);
    chk(dout_o, 5'h1f);
    setb(0, 0);
    chk(dout_o, 5'h00);
    setb(1, 1);
    clr;
    en(2'h2);
    rd(-2);
    chk({ind_pair_two_o, ind_low_o, fail_flag_o}, 4'he);
    limits_off_local_i = 1;
    cyc;
    limits_off_local_i = 0;
    chk(pair_enable_o, 2'h0);
    clr;
    rd(-2);
    chk(fail_flag_o, 2'h0);
    en(2'h3);
    setb(3, 1);
    chk({pulse_mode_o, summary_latch_o}, 2'h1);
    // Each release source in turn: control source pass, then new scan
    for (int k = 1; k < 3; k++) begin
      rd(1);
      rd(0);
      cyc(2);
      chk({summary_fail_output_o, seen[4]}, 2'h3);
      {scan_start_i, control_source_pass_i} = k[1:0];
      cyc;
      {scan_start_i, control_source_pass_i} = 2'h0;
      cyc;
      chk(seen[4], 1'b0);
    end
    setb(3, 0);
    setb(2, 1);
    chk({pulse_mode_o, summary_latch_o}, 2'h2);
    pulse_time_ms_i = 27'h1;
    pulse_time_wr_i = 1;
    cyc;
    pulse_time_wr_i = 0;
    chk(pulse_time_ms_o, 27'h1);
    rd(-1);
    cyc(49990);
    chk(seen, 5'h11);
    cyc(20);
    chk(seen, 5'h00);
    rd(2);
    cyc(100);
    chk(seen, 5'h1a);
    rd(0);
    chk(seen, 5'h00);
    final_report;
  end
endmodule // tb_limit_test_outputs
`default_nettype wire
